/* File: design/usbevt_params.svh */
/*
  Constants of the USB device event handler: register offsets, field positions, reset values and timing counts.
  Assumes inclusion by the top module and the test bench only.
*/
`ifndef USBEVT_PARAMS_SVH
`define USBEVT_PARAMS_SVH

`define UE_OFS_CTRL 12'h000
`define UE_OFS_IRQ0 12'h004
`define UE_OFS_IRQ1 12'h008
`define UE_OFS_WAKE 12'h00C
`define UE_OFS_WAKE_MASK 12'h010
`define UE_OFS_IRQ0_MASK 12'h014
`define UE_OFS_REQEVT 12'h018
`define UE_OFS_CONFIG 12'h01C
`define UE_OFS_ADDR 12'h020
`define UE_OFS_EP 12'h024
`define UE_OFS_CNT 12'h028
`define UE_OFS_STATE 12'h02C

// Control register bits
`define UE_CTL_SLEEP 0
`define UE_CTL_WAKE 1
// First status register bits
`define UE_I0_BUSEVT 0
`define UE_I0_SETUP 1
`define UE_I0_SETUP_DLY 2
// Second status register bits
`define UE_I1_SUSPEND 0
// Wakeup source / mask bits
`define UE_WK_RESUME 0
`define UE_WK_RESET 1
// Bus event mask bits
`define UE_M0_RESET 0
`define UE_M0_RESUME 1
`define UE_M0_BUSEVT 2
// Request event bits
`define UE_RQ_SETCFG 0
`define UE_RQ_SETHALT 1
`define UE_RQ_CLRHALT 2
`define UE_RQ_SETRWU 3
`define UE_RQ_CLRRWU 4
`define UE_RQ_SETIF 5

`define UE_RST_WAKE_MASK 8'h03
`define UE_RST_IRQ0_MASK 8'h07
`define UE_RST_EP_ENA 8'h03
`define UE_CFG_ONE 8'h01

// Bus idle time before suspend, in microseconds
`define UE_SUSPEND_US 3000
`define UE_CLK_MHZ 125
`define UE_SUSPEND_CYC (`UE_SUSPEND_US * `UE_CLK_MHZ + 1)

// Standard request codes
`define UE_REQ_CLR_FEAT 8'h01
`define UE_REQ_SET_FEAT 8'h03
`define UE_REQ_SET_ADDR 8'h05
`define UE_REQ_GET_CFG 8'h08
`define UE_REQ_SET_CFG 8'h09
`define UE_REQ_GET_IF 8'h0A
`define UE_REQ_SET_IF 8'h0B

`endif

/* File: design/usbevt_pkg.sv */
/*
  Types of the USB device event handler.
  Assumes the params header for the field layout.
*/
package usbevt_pkg;
  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
  } usbevt_setup_t;

  typedef struct packed {
    logic ack;
    logic nak;
    logic stall;
    logic discard;
  } usbevt_answer_t;

  typedef struct packed {
    logic [7:0] in_data;
    logic in_valid;
  } usbevt_reply_t;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} usbevt_pwr_t;
endpackage : usbevt_pkg

/* File: design/usbevt_top.sv */
/*
  USB device event handler: resets, suspend/resume, setup arrival, hardware standard requests, endpoint enables.
  Assumes an AHB-Lite master for firmware, a packet engine that reports decoded tokens, and an async wake pin.
*/
`timescale 1ns/1ns
`include "usbevt_params.svh"

module usbevt_top
  import usbevt_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Packet engine events, same clock
  input wire logic BUS_RESET,
  input wire logic BUS_IDLE,
  input wire logic SETUP_TOKEN,
  input wire usbevt_setup_t SETUP_DATA,
  input wire logic OUT_TOKEN,
  input wire logic [1:0] OUT_EP,
  input wire logic OUT_TOGGLE,
  // Asynchronous wake detect pin
  input wire logic BUS_WAKE_ASYNC,
  // Answers and state
  output usbevt_answer_t ANSWER,
  output usbevt_reply_t REPLY,
  output logic [6:0] DEV_ADDR,
  output logic [7:0] EP_ENABLE,
  output logic [3:0] DATA_TOGGLE,
  output logic POWER_DOWN,
  output logic OSC_RUN,
  output logic MCU_IRQ_LINE_THREE,
  output logic WAKE_IRQ
);

  logic [7:0] engine_ctrl_ff;
  logic [7:0] irq_status_first_ff;
  logic [7:0] irq_status_second_ff;
  logic [7:0] wakeup_source_reg_ff;
  logic [7:0] wake_mask_ff;
  logic [7:0] irq0_mask_ff;
  logic [7:0] request_event_status_ff;
  logic [7:0] config_number_reg_ff;
  logic [6:0] addr_ff;
  logic [3:0] stall_ff;
  logic [6:0] ctrl_rx_count_ff;
  logic [6:0] ctrl_tx_count_ff;
  logic ctrl_tx_bit_ff;
  logic [3:0] data_toggle_ff;
  logic [7:0] ep_enable_ff;
  logic [31:0] idle_cnt_ff;
  logic [1:0] wake_sync_ff;
  logic wake_seen_ff;
  logic [11:0] a_addr_ff;
  logic a_write_ff;
  logic a_valid_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  usbevt_answer_t answer_ff;
  usbevt_reply_t reply_ff;
  usbevt_pwr_t pwr_ff;
  logic power_down_ff;
  logic mcu_irq_ff;
  logic wake_irq_ff;

  logic wr;
  logic rd_take;
  logic bus_reset_ok;
  logic wake_evt;
  logic std_req;
  logic is_cfg_req;
  logic bad_cfg;
  logic handled;
  logic [7:0] nxt_irq0_set;
  logic [7:0] nxt_wake_set;
  logic [7:0] nxt_req_set;
  logic [7:0] wd;

  // Bus reset only counts while the power state is ST_RUN
  assign bus_reset_ok = BUS_RESET && pwr_ff == ST_RUN;
  assign wr = a_valid_ff && a_write_ff;
  assign wd = HWDATA[7:0];
  assign rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign std_req = SETUP_TOKEN && SETUP_DATA.req_type[6:5] == 2'b00;
  assign is_cfg_req = std_req && SETUP_DATA.request == `UE_REQ_SET_CFG;
  assign bad_cfg = is_cfg_req && SETUP_DATA.value[7:0] > `UE_CFG_ONE;
  // Hardware-handled request decode
  assign handled = std_req && (SETUP_DATA.request == `UE_REQ_SET_CFG || SETUP_DATA.request == `UE_REQ_GET_CFG ||
    SETUP_DATA.request == `UE_REQ_SET_FEAT || SETUP_DATA.request == `UE_REQ_CLR_FEAT ||
    SETUP_DATA.request == `UE_REQ_GET_IF || SETUP_DATA.request == `UE_REQ_SET_IF ||
    SETUP_DATA.request == `UE_REQ_SET_ADDR);

  // Async wake caught by a latch flop, then two-stage sync
  logic wake_latch_ff;
  logic wake_clr_ff;
  always_ff @(posedge BUS_WAKE_ASYNC or posedge wake_clr_ff or negedge RESETN) begin
    if (!RESETN) begin
      wake_latch_ff <= 1'b0;
    end else if (wake_clr_ff) begin
      wake_latch_ff <= 1'b0;
    end else begin
      wake_latch_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      wake_sync_ff <= 2'b00;
      wake_seen_ff <= 1'b0;
      wake_clr_ff <= 1'b0;
    end else begin
      wake_sync_ff <= {wake_sync_ff[0], wake_latch_ff};
      wake_seen_ff <= wake_sync_ff[1];
      wake_clr_ff <= wake_sync_ff[1];
    end
  end
  // Only acts as a wakeup when sleeping and the resume source is open
  assign wake_evt = wake_sync_ff[1] && !wake_seen_ff && pwr_ff == ST_SLEEP && wake_mask_ff[`UE_WK_RESUME];

  // AHB-Lite address phase capture; zero-wait answer
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      a_valid_ff <= 1'b0;
      a_write_ff <= 1'b0;
      a_addr_ff <= 12'h000;
      hreadyout_ff <= 1'b1;
    end else begin
      a_valid_ff <= HSEL && HREADY && HTRANS[1];
      a_write_ff <= HWRITE;
      a_addr_ff <= HADDR;
      hreadyout_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (HADDR)
        `UE_OFS_CTRL: hrdata_ff <= {24'h00_0000, engine_ctrl_ff};
        `UE_OFS_IRQ0: hrdata_ff <= {24'h00_0000, irq_status_first_ff};
        `UE_OFS_IRQ1: hrdata_ff <= {24'h00_0000, irq_status_second_ff};
        `UE_OFS_WAKE: hrdata_ff <= {24'h00_0000, wakeup_source_reg_ff};
        `UE_OFS_WAKE_MASK: hrdata_ff <= {24'h00_0000, wake_mask_ff};
        `UE_OFS_IRQ0_MASK: hrdata_ff <= {24'h00_0000, irq0_mask_ff};
        `UE_OFS_REQEVT: hrdata_ff <= {24'h00_0000, request_event_status_ff};
        `UE_OFS_CONFIG: hrdata_ff <= {24'h00_0000, config_number_reg_ff};
        `UE_OFS_ADDR: hrdata_ff <= {25'h000_0000, addr_ff};
        `UE_OFS_EP: hrdata_ff <= {16'h0000, ep_enable_ff, data_toggle_ff, stall_ff};
        `UE_OFS_CNT: hrdata_ff <= {16'h0000, ctrl_tx_bit_ff, ctrl_tx_count_ff, 1'b0, ctrl_rx_count_ff};
        `UE_OFS_STATE: hrdata_ff <= {30'h0000_0000, pwr_ff};
        default: hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits; firmware sets sleep and wake
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      engine_ctrl_ff <= 8'h00;
    end else if (bus_reset_ok) begin
      engine_ctrl_ff <= 8'h00;
    end else if (wake_evt) begin
      engine_ctrl_ff[`UE_CTL_SLEEP] <= 1'b0;
    end else if (wr && a_addr_ff == `UE_OFS_CTRL) begin
      engine_ctrl_ff <= wd;
    end
  end

  // Power state: sleep bit moves to ST_SLEEP, wake to ST_WAKE; OSC_RUN stays high throughout
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pwr_ff <= ST_RUN;
    end else begin
      unique case (pwr_ff)
        ST_RUN: if (engine_ctrl_ff[`UE_CTL_SLEEP]) pwr_ff <= ST_SLEEP;
        ST_SLEEP: if (wake_evt || engine_ctrl_ff[`UE_CTL_WAKE]) pwr_ff <= ST_WAKE;
        ST_WAKE: if (!engine_ctrl_ff[`UE_CTL_SLEEP]) pwr_ff <= ST_RUN;
      endcase
    end
  end

  // Power-down pin registered; mirrors entry to and exit from the sleep state
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      power_down_ff <= 1'b0;
    end else if (pwr_ff == ST_RUN && engine_ctrl_ff[`UE_CTL_SLEEP]) begin
      power_down_ff <= 1'b1;
    end else if (pwr_ff == ST_SLEEP && (wake_evt || engine_ctrl_ff[`UE_CTL_WAKE])) begin
      power_down_ff <= 1'b0;
    end
  end

  // Event set terms
  always_comb begin
    nxt_irq0_set = 8'h00;
    nxt_wake_set = 8'h00;
    nxt_req_set = 8'h00;
    if (bus_reset_ok) begin
      nxt_wake_set[`UE_WK_RESET] = 1'b1;
      nxt_irq0_set[`UE_I0_BUSEVT] = irq0_mask_ff[`UE_M0_RESET] && irq0_mask_ff[`UE_M0_BUSEVT];
    end
    if (wake_evt) begin
      nxt_wake_set[`UE_WK_RESUME] = 1'b1;
      nxt_irq0_set[`UE_I0_BUSEVT] = irq0_mask_ff[`UE_M0_RESUME] && irq0_mask_ff[`UE_M0_BUSEVT];
    end
    if (SETUP_TOKEN && !bus_reset_ok && !handled) begin
      nxt_irq0_set[`UE_I0_SETUP] = 1'b1;
    end
    if (std_req && !bad_cfg && !bus_reset_ok) begin
      // Address, get-interface and get-config are silent
      unique case (SETUP_DATA.request)
        `UE_REQ_SET_CFG: nxt_req_set[`UE_RQ_SETCFG] = 1'b1;
        `UE_REQ_SET_IF: nxt_req_set[`UE_RQ_SETIF] = 1'b1;
        `UE_REQ_SET_FEAT: nxt_req_set[SETUP_DATA.req_type[1:0] == 2'b10 ? `UE_RQ_SETHALT : `UE_RQ_SETRWU] = 1'b1;
        `UE_REQ_CLR_FEAT: nxt_req_set[SETUP_DATA.req_type[1:0] == 2'b10 ? `UE_RQ_CLRHALT : `UE_RQ_CLRRWU] = 1'b1;
        default: nxt_req_set = 8'h00;
      endcase
    end
  end

  // Sticky flags; write one clears, a coincident set wins
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      irq_status_first_ff <= 8'h00;
      irq_status_second_ff <= 8'h00;
      wakeup_source_reg_ff <= 8'h00;
      request_event_status_ff <= 8'h00;
    end else begin
      irq_status_first_ff <= ((wr && a_addr_ff == `UE_OFS_IRQ0) ? irq_status_first_ff & ~wd : irq_status_first_ff)
        & (bus_reset_ok ? 8'hF9 : 8'hFF) | nxt_irq0_set;
      irq_status_second_ff <= ((wr && a_addr_ff == `UE_OFS_IRQ1) ? irq_status_second_ff & ~wd :
        irq_status_second_ff) | {7'h00, idle_cnt_ff == `UE_SUSPEND_CYC - 1};
      wakeup_source_reg_ff <= ((wr && a_addr_ff == `UE_OFS_WAKE) ? wakeup_source_reg_ff & ~wd :
        wakeup_source_reg_ff) | nxt_wake_set;
      request_event_status_ff <= ((wr && a_addr_ff == `UE_OFS_REQEVT) ? request_event_status_ff & ~wd :
        request_event_status_ff) | nxt_req_set;
    end
  end

  // Masks
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      wake_mask_ff <= `UE_RST_WAKE_MASK;
      irq0_mask_ff <= `UE_RST_IRQ0_MASK;
    end else begin
      if (wr && a_addr_ff == `UE_OFS_WAKE_MASK) wake_mask_ff <= wd;
      if (wr && a_addr_ff == `UE_OFS_IRQ0_MASK) irq0_mask_ff <= wd;
    end
  end

  // Idle counter, stops at limit so the suspend flag sets once per idle span
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      idle_cnt_ff <= 32'h0000_0000;
    end else if (!BUS_IDLE || pwr_ff != ST_RUN) begin
      idle_cnt_ff <= 32'h0000_0000;
    end else if (idle_cnt_ff != `UE_SUSPEND_CYC) begin
      idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
    end
  end

  // Configuration, address, endpoint enables
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      config_number_reg_ff <= 8'h00;
      addr_ff <= 7'h00;
      ep_enable_ff <= 8'h00;
    end else if (bus_reset_ok) begin
      config_number_reg_ff <= 8'h00;
      addr_ff <= 7'h00;
      ep_enable_ff <= `UE_RST_EP_ENA;
    end else begin
      if (is_cfg_req && !bad_cfg) config_number_reg_ff <= SETUP_DATA.value[7:0];
      if (std_req && SETUP_DATA.request == `UE_REQ_SET_ADDR) addr_ff <= SETUP_DATA.value[6:0];
      ep_enable_ff <= (config_number_reg_ff == `UE_CFG_ONE) ? 8'hFF : `UE_RST_EP_ENA;
    end
  end

  // Stalls and toggles; one generate iteration per endpoint, four in all
  for (genvar g = 0; g < 4; g++) begin : g_ep
    always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
        stall_ff[g] <= 1'b0;
        data_toggle_ff[g] <= 1'b0;
      end else if (bus_reset_ok) begin
        stall_ff[g] <= 1'b0;
        data_toggle_ff[g] <= 1'b0;
      end else if (SETUP_TOKEN && g < 2) begin
        stall_ff[g] <= bad_cfg;
        data_toggle_ff[g] <= 1'b1;
      end else if (std_req && SETUP_DATA.index[1:0] == 2'(g) && SETUP_DATA.req_type[1:0] == 2'b10 &&
          (SETUP_DATA.request == `UE_REQ_SET_FEAT || SETUP_DATA.request == `UE_REQ_CLR_FEAT)) begin
        stall_ff[g] <= SETUP_DATA.request == `UE_REQ_SET_FEAT;
      end else if (OUT_TOKEN && OUT_EP == 2'(g) && OUT_TOGGLE == data_toggle_ff[g] && ep_enable_ff[g] &&
          !stall_ff[g] && !(g == 0 && irq_status_first_ff[`UE_I0_SETUP])) begin
        // Only a packet that is really accepted advances the toggle
        data_toggle_ff[g] <= ~data_toggle_ff[g];
      end
    end
  end

  // Control byte counts and transmit bit
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_rx_count_ff <= 7'h00;
      ctrl_tx_count_ff <= 7'h00;
      ctrl_tx_bit_ff <= 1'b0;
    end else if (bus_reset_ok || SETUP_TOKEN) begin
      ctrl_rx_count_ff <= 7'h00;
      ctrl_tx_count_ff <= 7'h00;
      ctrl_tx_bit_ff <= 1'b0;
    end else if (wr && a_addr_ff == `UE_OFS_CNT) begin
      ctrl_rx_count_ff <= wd[6:0];
      ctrl_tx_count_ff <= HWDATA[14:8];
      ctrl_tx_bit_ff <= HWDATA[15];
    end
  end

  // Handshake to the packet engine
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      answer_ff <= '0;
      reply_ff <= '0;
    end else begin
      answer_ff <= '0;
      reply_ff <= '0;
      if (SETUP_TOKEN) begin
        answer_ff.ack <= 1'b1;
        reply_ff.in_valid <= std_req && (SETUP_DATA.request == `UE_REQ_GET_CFG ||
          SETUP_DATA.request == `UE_REQ_GET_IF);
        reply_ff.in_data <= (SETUP_DATA.request == `UE_REQ_GET_CFG) ? config_number_reg_ff : 8'h00;
      end else if (OUT_TOKEN) begin
        if (!ep_enable_ff[OUT_EP] || stall_ff[OUT_EP]) begin
          answer_ff.stall <= stall_ff[OUT_EP];
          answer_ff.nak <= !stall_ff[OUT_EP];
        end else if (OUT_EP == 2'd0 && irq_status_first_ff[`UE_I0_SETUP]) begin
          answer_ff.nak <= 1'b1;
        end else begin
          answer_ff.ack <= 1'b1;
          answer_ff.discard <= OUT_TOGGLE != data_toggle_ff[OUT_EP];
        end
      end
    end
  end

  // Interrupt lines out, registered
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      mcu_irq_ff <= 1'b0;
      wake_irq_ff <= 1'b0;
    end else begin
      mcu_irq_ff <= |request_event_status_ff;
      wake_irq_ff <= |(wakeup_source_reg_ff & wake_mask_ff);
    end
  end

  assign HRDATA = hrdata_ff;
  assign HREADYOUT = hreadyout_ff;
  assign HRESP = 1'b0;
  assign ANSWER = answer_ff;
  assign REPLY = reply_ff;
  assign DEV_ADDR = addr_ff;
  assign EP_ENABLE = ep_enable_ff;
  assign DATA_TOGGLE = data_toggle_ff;
  assign POWER_DOWN = power_down_ff;
  assign OSC_RUN = 1'b1;
  assign MCU_IRQ_LINE_THREE = mcu_irq_ff;
  assign WAKE_IRQ = wake_irq_ff;

endmodule : usbevt_top

/* File: testbench/usbevt_checker.sv */
/*
  Port checker for the event handler: resets, setup arrival, toggles, resume.
  Assumes one clock domain and a bind onto usbevt_top.
*/
`timescale 1ns/1ns
module usbevt_checker
  import usbevt_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Engine events
  input wire logic BUS_RESET,
  input wire logic SETUP_TOKEN,
  input wire logic OUT_TOKEN,
  input wire logic [1:0] OUT_EP,
  input wire logic OUT_TOGGLE,
  input wire logic BUS_WAKE_ASYNC,
  // Watched outputs
  input wire usbevt_answer_t ANSWER,
  input wire logic [6:0] DEV_ADDR,
  input wire logic [7:0] EP_ENABLE,
  input wire logic [3:0] DATA_TOGGLE,
  input wire logic POWER_DOWN,
  input wire logic OSC_RUN
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  property p_osc_run;
    OSC_RUN;
  endproperty
  a_osc_run: assert property (p_osc_run) else $error("oscillator stopped");
  property p_addr_clear;
    BUS_RESET |-> ##[1:3] DEV_ADDR == 7'h00;
  endproperty
  a_addr_clear: assert property (p_addr_clear) else $error("address kept over bus reset");
  property p_tog_clear;
    BUS_RESET |-> ##[1:3] DATA_TOGGLE == 4'h0;
  endproperty
  a_tog_clear: assert property (p_tog_clear) else $error("toggles kept over bus reset");
  property p_ctrl_ena;
    $fell(BUS_RESET) |-> ##[0:2] EP_ENABLE == 8'h03;
  endproperty
  a_ctrl_ena: assert property (p_ctrl_ena) else $error("control endpoint not enabled");
  property p_setup_ack;
    SETUP_TOKEN |=> ANSWER.ack && !ANSWER.nak && !ANSWER.stall;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup not acknowledged");
  property p_setup_tog;
    SETUP_TOKEN |-> ##[1:2] DATA_TOGGLE[1:0] == 2'h3;
  endproperty
  a_setup_tog: assert property (p_setup_tog) else $error("control toggles not one");
  // Only a clean acceptance is forbidden; NAK or STALL may still win
  property p_bad_tog;
    OUT_TOKEN && OUT_TOGGLE != DATA_TOGGLE[OUT_EP] |=> !(ANSWER.ack && !ANSWER.discard);
  endproperty
  a_bad_tog: assert property (p_bad_tog) else $error("wrong toggle data kept");
  property p_resume;
    $rose(BUS_WAKE_ASYNC) && POWER_DOWN |-> ##[1:8] !POWER_DOWN;
  endproperty
  a_resume: assert property (p_resume) else $error("no wake from power down");
endmodule : usbevt_checker

bind usbevt_top usbevt_checker u_checker (
  .CLOCK(CLOCK), .RESETN(RESETN), .BUS_RESET(BUS_RESET), .SETUP_TOKEN(SETUP_TOKEN),
  .OUT_TOKEN(OUT_TOKEN), .OUT_EP(OUT_EP), .OUT_TOGGLE(OUT_TOGGLE), .BUS_WAKE_ASYNC(BUS_WAKE_ASYNC),
  .ANSWER(ANSWER), .DEV_ADDR(DEV_ADDR), .EP_ENABLE(EP_ENABLE), .DATA_TOGGLE(DATA_TOGGLE),
  .POWER_DOWN(POWER_DOWN), .OSC_RUN(OSC_RUN)
);

/* File: testbench/usbevt_host_model.sv */
/*
  Host-side model: bus reset, setup and OUT tokens, async wake line.
  Assumes the handler samples tokens at the rising clock edge.
*/
`timescale 1ns/1ns
module usbevt_host_model
  import usbevt_pkg::*;
(
  // Clock
  input wire logic CLOCK,
  // Events toward the device
  output logic BUS_RESET = 1'b0,
  output logic SETUP_TOKEN = 1'b0,
  output usbevt_setup_t SETUP_DATA = '0,
  output logic OUT_TOKEN = 1'b0,
  output logic [1:0] OUT_EP = 2'h0,
  output logic OUT_TOGGLE = 1'b0,
  output logic BUS_WAKE_ASYNC = 1'b0
);
  // Idle lines show the inverse of the last value, so stale data never looks valid
  task automatic send_setup(input logic [7:0] rtype, input logic [7:0] req, input logic [15:0] val);
    @(posedge CLOCK);
    SETUP_TOKEN <= 1'b1;
    SETUP_DATA <= {rtype, req, val, 16'h0000};
    @(posedge CLOCK);
    SETUP_TOKEN <= 1'b0;
    SETUP_DATA <= ~{rtype, req, val, 16'h0000};
  endtask : send_setup
  task automatic out_pkt(input logic [1:0] ep, input logic tog);
    @(posedge CLOCK);
    OUT_TOKEN <= 1'b1;
    OUT_EP <= ep;
    OUT_TOGGLE <= tog;
    @(posedge CLOCK);
    OUT_TOKEN <= 1'b0;
    OUT_EP <= ~ep;
    OUT_TOGGLE <= ~tog;
  endtask : out_pkt
  task automatic bus_reset(input int cycles);
    @(posedge CLOCK);
    BUS_RESET <= 1'b1;
    repeat (cycles) @(posedge CLOCK);
    BUS_RESET <= 1'b0;
  endtask : bus_reset
  // Edge placed off the clock on purpose: the wake path must not need it
  task automatic wake;
    @(posedge CLOCK);
    #3;
    BUS_WAKE_ASYNC <= 1'b1;
    repeat (4) @(posedge CLOCK);
    BUS_WAKE_ASYNC <= 1'b0;
  endtask : wake
endmodule : usbevt_host_model

/* File: testbench/usbevt_top_test.sv */
/*
  Self-checking bench of the event handler over AHB-Lite and the host model.
  Assumes the params header offsets and the checker bound onto the top.
*/
`timescale 1ns/1ns
`include "usbevt_params.svh"
module usbevt_top_test
  import usbevt_pkg::*;
;
  logic clock, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans, out_ep;
  logic [31:0] hwdata, hrdata, rdv;
  logic bus_reset, setup_token, out_token, out_toggle, bus_wake;
  usbevt_setup_t setup_data;
  usbevt_answer_t answer;
  usbevt_reply_t reply;
  logic [6:0] dev_addr;
  logic [7:0] ep_enable;
  logic [3:0] data_toggle;
  logic power_down, osc_run, mcu_irq, wake_irq;
  int fail_count, comparisons, n;
  assign hready = hreadyout;

  usbevt_top uut (
    .CLOCK(clock), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .BUS_RESET(bus_reset), .BUS_IDLE(1'b0), .SETUP_TOKEN(setup_token), .SETUP_DATA(setup_data),
    .OUT_TOKEN(out_token), .OUT_EP(out_ep), .OUT_TOGGLE(out_toggle), .BUS_WAKE_ASYNC(bus_wake),
    .ANSWER(answer), .REPLY(reply), .DEV_ADDR(dev_addr), .EP_ENABLE(ep_enable), .DATA_TOGGLE(data_toggle),
    .POWER_DOWN(power_down), .OSC_RUN(osc_run), .MCU_IRQ_LINE_THREE(mcu_irq), .WAKE_IRQ(wake_irq)
  );
  usbevt_host_model host (
    .CLOCK(clock), .BUS_RESET(bus_reset), .SETUP_TOKEN(setup_token), .SETUP_DATA(setup_data),
    .OUT_TOKEN(out_token), .OUT_EP(out_ep), .OUT_TOGGLE(out_toggle), .BUS_WAKE_ASYNC(bus_wake)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic guard;
    if (n >= 50) begin
      fail_count++;
      stop_test();
    end
  endtask : guard
  task automatic wait_ready;
    n = 0;
    @(posedge clock);
    while (hready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    guard();
  endtask : wait_ready
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdv = hrdata;
  endtask : ahb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check(rdv, exp);
  endtask : rdchk
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task automatic t_bus_reset;
    host.bus_reset(3);
    settle();
    check(ep_enable, 8'h03);
    host.send_setup(8'h00, `UE_REQ_SET_ADDR, 16'h002A);
    settle();
    check(dev_addr, 7'h2A);
    host.send_setup(8'h00, `UE_REQ_SET_CFG, 16'h0001);
    settle();
    check(ep_enable, 8'hFF);
    rdchk(`UE_OFS_CONFIG, 32'h0000_0001);
    host.send_setup(8'h80, `UE_REQ_GET_CFG, 16'h0000);
    #1;
    check(reply, 9'h003);
    host.send_setup(8'h81, `UE_REQ_GET_IF, 16'h0000);
    #1;
    check(reply, 9'h001);
    ahb(1'b1, `UE_OFS_REQEVT, 32'h0000_00FF);
    host.bus_reset(3);
    settle();
    check(dev_addr, 7'h00);
    check(ep_enable, 8'h03);
    check(data_toggle, 4'h0);
    check(wake_irq, 1'b1);
    rdchk(`UE_OFS_CONFIG, 32'h0000_0000);
    rdchk(`UE_OFS_IRQ0, 32'h0000_0001);
    rdchk(`UE_OFS_WAKE, 32'h0000_0002);
    ahb(1'b1, `UE_OFS_IRQ0, 32'h0000_00FF);
    ahb(1'b1, `UE_OFS_WAKE, 32'h0000_00FF);
    $display("bus reset test done");
  endtask : t_bus_reset

  task automatic t_requests;
    logic [31:0] tbl [6];
    tbl = '{32'h0009_0001, 32'h0203_0000, 32'h0201_0000, 32'h0003_0001, 32'h0001_0001, 32'h010B_0000};
    for (int i = 0; i < 6; i++) begin
      host.send_setup(tbl[i][31:24], tbl[i][23:16], tbl[i][15:0]);
      settle();
      check(mcu_irq, 1'b1);
      rdchk(`UE_OFS_REQEVT, 32'h0000_0001 << i);
      ahb(1'b1, `UE_OFS_REQEVT, 32'h0000_00FF);
    end
    host.send_setup(8'h00, `UE_REQ_SET_ADDR, 16'h0000);
    settle();
    rdchk(`UE_OFS_REQEVT, 32'h0000_0000);
    $display("request test done");
  endtask : t_requests

  task automatic t_setup;
    host.send_setup(8'h80, 8'h06, 16'h0100);
    #1;
    check(answer, 4'h8);
    settle();
    check(data_toggle[1:0], 2'h3);
    rdchk(`UE_OFS_IRQ0, 32'h0000_0002);
    host.out_pkt(2'h0, 1'b1);
    #1;
    check(answer, 4'h4);
    ahb(1'b1, `UE_OFS_IRQ0, 32'h0000_0002);
    host.out_pkt(2'h0, 1'b1);
    #1;
    check(answer, 4'h8);
    host.out_pkt(2'h0, 1'b1);
    #1;
    check(answer, 4'h9);
    host.send_setup(8'h00, `UE_REQ_SET_CFG, 16'h0002);
    settle();
    host.out_pkt(2'h0, 1'b1);
    #1;
    check(answer.stall, 1'b1);
    host.send_setup(8'h00, `UE_REQ_SET_CFG, 16'h0001);
    settle();
    host.out_pkt(2'h0, 1'b1);
    #1;
    check(answer, 4'h8);
    $display("setup test done");
  endtask : t_setup

  task automatic t_resume;
    ahb(1'b1, `UE_OFS_CTRL, 32'h0000_0001);
    settle();
    check(power_down, 1'b1);
    host.wake();
    n = 0;
    while (power_down !== 1'b0 && n < 50) begin
      n++;
      @(posedge clock);
    end
    guard();
    rdchk(`UE_OFS_CTRL, 32'h0000_0000);
    rdchk(`UE_OFS_WAKE, 32'h0000_0001);
    check(wake_irq, 1'b1);
    ahb(1'b0, `UE_OFS_IRQ0, 32'h0000_0000);
    check(rdv[0], 1'b1);
    ahb(1'b1, `UE_OFS_WAKE, 32'h0000_00FF);
    ahb(1'b1, `UE_OFS_CTRL, 32'h0000_0001);
    ahb(1'b1, `UE_OFS_CTRL, 32'h0000_0002);
    settle();
    check(power_down, 1'b0);
    $display("resume test done");
  endtask : t_resume

  task automatic t_ext_reset;
    ahb(1'b1, `UE_OFS_CTRL, 32'h0000_0001);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(ep_enable, 8'h00);
    check(power_down, 1'b0);
    check(osc_run, 1'b1);
    @(posedge clock);
    resetn <= 1'b1;
    rdchk(`UE_OFS_CONFIG, 32'h0000_0000);
    rdchk(`UE_OFS_IRQ0_MASK, 32'h0000_0007);
    rdchk(`UE_OFS_WAKE_MASK, 32'h0000_0003);
    rdchk(12'h0FC, 32'h0000_0000);
    $display("external reset test done");
  endtask : t_ext_reset

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    fail_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    t_bus_reset();
    t_requests();
    t_setup();
    t_resume();
    t_ext_reset();
    stop_test();
  end
endmodule : usbevt_top_test
